/* rtl/rls_pkg.sv */
// Constants, field layouts and types of the registered logic sequencer.
// Assumes a 32-bit AXI4-Lite bus with 10-bit byte addresses.
package rls_pkg;
  // Array dimensions
  localparam int unsigned NUM_IN    = 4;
  localparam int unsigned NUM_BIO   = 8;
  localparam int unsigned NUM_FF    = 4;
  localparam int unsigned NUM_VAR   = 17;
  localparam int unsigned NUM_LOGIC = 32;
  localparam int unsigned NUM_TERM  = 45;
  localparam int unsigned NUM_SUM   = 21;
  // Product gate input positions
  localparam int unsigned VAR_I = 0;
  localparam int unsigned VAR_B = 4;
  localparam int unsigned VAR_Q = 12;
  localparam int unsigned VAR_C = 16;
  // Control product gates
  localparam int unsigned TERM_DIR  = 32;
  localparam int unsigned TERM_LOAD = 40;
  localparam int unsigned TERM_FOLD = 44;
  // Sum gate positions
  localparam int unsigned SUM_B  = 0;
  localparam int unsigned SUM_J  = 8;
  localparam int unsigned SUM_K  = 12;
  localparam int unsigned SUM_PR = 16;
  localparam int unsigned SUM_C  = 20;
  // Bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned IDX_W  = 8;
  localparam int unsigned IDX_LSB = 2;
  // Register word indices (byte address is four times)
  localparam logic [7:0] IDX_TRUE = 8'h00;
  localparam logic [7:0] IDX_COMP = 8'h40;
  localparam logic [7:0] IDX_SUM  = 8'h80;
  localparam logic [7:0] IDX_POL  = 8'hC0;
  localparam logic [7:0] IDX_MODE = 8'hC1;
  localparam logic [7:0] IDX_OUT  = 8'hC2;
  localparam logic [7:0] IDX_STAT = 8'hC3;
  // Field positions in the output control word
  localparam int unsigned OUT_ALWAYS = 4;
  // Reset values: links intact, gates disabled, D mode, outputs on
  localparam logic [16:0] RST_MASK = 17'h1_FFFF;
  localparam logic [31:0] RST_SUM  = 32'h0000_0000;
  localparam logic [7:0]  RST_POL  = 8'h00;
  localparam logic [7:0]  RST_MODE = 8'h00;
  localparam logic [4:0]  RST_OUT  = 5'h1F;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Flip-flop modes, two bits per flip-flop
  typedef enum logic [1:0] {
    RLS_MODE_D   = 2'h0,
    RLS_MODE_JK  = 2'h1,
    RLS_MODE_JKD = 2'h3,
    RLS_MODE_T   = 2'h2
  } rls_ff_mode_e;
endpackage

/* rtl/rls_reg_if.sv */
// Register access carrier between the bus slave and the register file.
// Assumes one clock; all signals are sampled at aclk.
interface rls_reg_if;
  logic        wr_en;    // One-cycle write pulse
  logic [7:0]  wr_idx;   // Word index of write
  logic [31:0] wr_data;  // Write data
  logic [3:0]  wr_strb;  // Byte enables
  logic        wr_ok;    // Write index is mapped and writable
  logic [7:0]  rd_idx;   // Word index of read
  logic [31:0] rd_data;  // Read data
  logic        rd_ok;    // Read index is mapped
  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 input  wr_ok, rd_data, rd_ok);
  modport regs  (input  wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 output wr_ok, rd_data, rd_ok);
endinterface

/* rtl/rls_axil_slave.sv */
// AXI4-Lite slave front end for the sequencer registers.
// Assumes aclk at 200 MHz and a synchronous active-low reset.
module rls_axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data
  input  wire logic [9:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address and data
  input  wire logic [9:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register file side
  rls_reg_if.slave         rif
);
  logic        aw_held_reg;  // Address captured
  logic [7:0]  aw_idx_reg;   // Captured word index
  logic        w_held_reg;   // Data captured
  logic [31:0] wdata_reg;    // Captured data
  logic [3:0]  wstrb_reg;    // Captured strobes
  logic        bvalid_reg;   // Response pending
  logic [1:0]  bresp_reg;    // Response code
  logic        rvalid_reg;   // Read data pending
  logic [31:0] rdata_reg;    // Read data
  logic [1:0]  rresp_reg;    // Read code
  logic        wr_fire;      // Both halves present

  // Handshake and strobe decode
  assign awready     = !aw_held_reg && !bvalid_reg;
  assign wready      = !w_held_reg && !bvalid_reg;
  assign arready     = !rvalid_reg;
  assign wr_fire     = aw_held_reg && w_held_reg;
  assign rif.wr_en   = wr_fire;
  assign rif.wr_idx  = aw_idx_reg;
  assign rif.wr_data = wdata_reg;
  assign rif.wr_strb = wstrb_reg;
  assign rif.rd_idx  = araddr[rls_pkg::IDX_LSB +: rls_pkg::IDX_W];
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_idx_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= awaddr[rls_pkg::IDX_LSB +: rls_pkg::IDX_W];
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
    end
  end

  // Write response after the store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= rls_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= rif.wr_ok ? rls_pkg::RESP_OKAY : rls_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= rls_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rif.rd_data;
      rresp_reg  <= rif.rd_ok ? rls_pkg::RESP_OKAY : rls_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

/* rtl/rls_and_array.sv */
// Programmable AND plane: one product gate per mask pair.
// Assumes masks come from the register file; purely combinational.
module rls_and_array (
  // Gate inputs, true polarity
  input  wire logic [16:0]       vars,
  // Link masks per gate
  input  wire logic [44:0][16:0] true_mask,
  input  wire logic [44:0][16:0] comp_mask,
  // Gate outputs
  output logic [44:0]            terms
);
  // One gate: every linked true input high, every linked complement low
  function automatic logic and_gate(input logic [16:0] v,
                                    input logic [16:0] tm,
                                    input logic [16:0] cm);
    and_gate = &((~tm | v) & (~cm | ~v));
  endfunction

  // Replicate over all gates
  for (genvar g = 0; g < rls_pkg::NUM_TERM; g++) begin : g_gate
    assign terms[g] = and_gate(vars, true_mask[g], comp_mask[g]);
  end
endmodule

/* rtl/rls_sequencer.sv */
// Registered logic sequencer: programmable AND/OR planes, complement
// array, four J-K/D/T flip-flops and pin drivers, programmed over AXI4-Lite.
// Assumes synchronous pin inputs and that the board resolves pin levels.
// Functional notes
// - Four dedicated, eight bidirectional, four registered pins.
// - Thirty-two logic, thirteen control, twenty-one sum gates.
// - Gates see inputs, lines, flip-flops, complement.
// - Complement array NORs selected product gates.
// - Every gate input usable true or complemented.
// - Bidirectional outputs have per-line XOR polarity.
// - Any logic gate may feed J, K.
// - Preset and reset come from sum gates.
// - Flip-flops change on rising clock; preset and reset act at once.
// - Fold-back gate turns J-K into D.
// - J-K, T or D mode by programming.
// - Load gates make flip-flops input registers.
// - Output enable high floats registered pins; the code keeps them driven while OUT_ALWAYS is set, as it is after reset.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module rls_sequencer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [9:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [9:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pin groups and counts
  // Dedicated inputs
  input  wire logic [3:0]  in_pins,
  // Bidirectional lines
  input  wire logic [7:0]  bio_in,
  output logic [7:0]       bio_out,
  output logic [7:0]       bio_oe,
  // Registered pins
  input  wire logic [3:0]  reg_in,
  output logic [3:0]       reg_out,
  output logic [3:0]       reg_oe,
  // Registered output enable, active low
  input  wire logic        oe_n
);
  // Register file
  logic [44:0][16:0] true_reg;    // True-polarity links
  logic [44:0][16:0] comp_reg;    // Complement links
  logic [20:0][31:0] sum_reg;     // OR plane links
  logic [7:0]        pol_reg;     // Line polarity
  logic [7:0]        mode_reg;    // Flip-flop modes
  logic [4:0]        out_reg;     // Output select and OE mode
  logic [3:0]        q_reg;       // Flip-flop state
  logic [3:0]        q_next;      // Next state

  // Array signals
  logic [16:0]       vars;        // Gate inputs
  logic [16:0]       vars_nc;     // Gate inputs without complement
  logic [44:0][16:0] true_nc;     // Links with complement cut
  logic [44:0][16:0] comp_nc;     // Links with complement cut
  logic [44:0]       terms_nc;    // First pass gates
  logic [44:0]       terms;       // Final gates
  logic [20:0]       sums;        // OR plane outputs
  logic              comp_out;    // Complement array output
  logic [3:0]        q_eff;       // State after preset/reset
  logic [3:0]        pre;         // Preset per flip-flop
  logic [3:0]        clr;         // Reset per flip-flop
  logic [16:0]       comp_bit;    // Complement input position

  // Bus side decode
  logic [31:0]       merged;      // Write merged with old
  logic [31:0]       old_word;    // Word being written
  logic [7:0]        wsel;        // Offset within block
  logic [7:0]        rsel;        // Offset within block
  logic              wr_true;     // Write to true links
  logic              wr_comp;     // Write to complement links
  logic              wr_sum;      // Write to OR links
  logic [31:0]       stat_word;   // Live state word

  // Carrier to the bus front end
  rls_reg_if rif ();

  // Index inside a block of registers
  // Widened so base plus count cannot wrap
  function automatic logic in_blk(input logic [7:0] idx,
                                  input logic [7:0] base,
                                  input int unsigned n);
    in_blk = (idx >= base) && (32'(idx) < 32'(base) + n);
  endfunction

  // Byte-lane merge under strobes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      lane_merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Any other mapped word
  function automatic logic is_misc(input logic [7:0] idx);
    is_misc = (idx == rls_pkg::IDX_POL) || (idx == rls_pkg::IDX_MODE) ||
              (idx == rls_pkg::IDX_OUT) || (idx == rls_pkg::IDX_STAT);
  endfunction

  // Bus front end
  // Handshakes and answer timing live here
  rls_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif)
  );

  // Write decode
  assign wr_true = in_blk(rif.wr_idx, rls_pkg::IDX_TRUE, rls_pkg::NUM_TERM);
  assign wr_comp = in_blk(rif.wr_idx, rls_pkg::IDX_COMP, rls_pkg::NUM_TERM);
  assign wr_sum  = in_blk(rif.wr_idx, rls_pkg::IDX_SUM, rls_pkg::NUM_SUM);
  assign wsel    = wr_true ? rif.wr_idx - rls_pkg::IDX_TRUE :
                   wr_comp ? rif.wr_idx - rls_pkg::IDX_COMP :
                   wr_sum  ? rif.wr_idx - rls_pkg::IDX_SUM  : 8'h00;
  // Status is read only: writes refused
  assign rif.wr_ok = wr_true || wr_comp || wr_sum ||
                     (is_misc(rif.wr_idx) && rif.wr_idx != rls_pkg::IDX_STAT);
  // Old word feeds the byte-lane merge
  assign old_word = wr_true ? 32'(true_reg[wsel]) :
                    wr_comp ? 32'(comp_reg[wsel]) :
                    wr_sum  ? sum_reg[wsel] :
                    (rif.wr_idx == rls_pkg::IDX_POL)  ? 32'(pol_reg)  :
                    (rif.wr_idx == rls_pkg::IDX_MODE) ? 32'(mode_reg) :
                    32'(out_reg);
  assign merged = lane_merge(old_word, rif.wr_data, rif.wr_strb);

  // Link planes: gate masks and OR masks
  // Refused writes leave every plane as is
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      true_reg <= {rls_pkg::NUM_TERM{rls_pkg::RST_MASK}};
      comp_reg <= {rls_pkg::NUM_TERM{rls_pkg::RST_MASK}};
      sum_reg  <= {rls_pkg::NUM_SUM{rls_pkg::RST_SUM}};
    end else if (rif.wr_en) begin
      if (wr_true) true_reg[wsel] <= merged[16:0];
      if (wr_comp) comp_reg[wsel] <= merged[16:0];
      if (wr_sum)  sum_reg[wsel]  <= merged;
    end
  end

  // Polarity, mode and output control words
  // Only mapped words change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_reg  <= rls_pkg::RST_POL;
      mode_reg <= rls_pkg::RST_MODE;
      out_reg  <= rls_pkg::RST_OUT;
    end else if (rif.wr_en) begin
      if (rif.wr_idx == rls_pkg::IDX_POL)  pol_reg  <= merged[7:0];
      if (rif.wr_idx == rls_pkg::IDX_MODE) mode_reg <= merged[7:0];
      if (rif.wr_idx == rls_pkg::IDX_OUT)  out_reg  <= merged[4:0];
    end
  end

  // Read selection
  assign rsel = in_blk(rif.rd_idx, rls_pkg::IDX_TRUE, rls_pkg::NUM_TERM) ?
                  rif.rd_idx - rls_pkg::IDX_TRUE :
                in_blk(rif.rd_idx, rls_pkg::IDX_COMP, rls_pkg::NUM_TERM) ?
                  rif.rd_idx - rls_pkg::IDX_COMP :
                in_blk(rif.rd_idx, rls_pkg::IDX_SUM, rls_pkg::NUM_SUM) ?
                  rif.rd_idx - rls_pkg::IDX_SUM : 8'h00;
  assign stat_word = {8'h00, q_eff, in_pins, bio_in, comp_out, 3'h0,
                      reg_in};
  assign rif.rd_ok = is_misc(rif.rd_idx) ||
    in_blk(rif.rd_idx, rls_pkg::IDX_TRUE, rls_pkg::NUM_TERM) ||
    in_blk(rif.rd_idx, rls_pkg::IDX_COMP, rls_pkg::NUM_TERM) ||
    in_blk(rif.rd_idx, rls_pkg::IDX_SUM, rls_pkg::NUM_SUM);
  // Unmapped reads return zero
  assign rif.rd_data =
    in_blk(rif.rd_idx, rls_pkg::IDX_TRUE, rls_pkg::NUM_TERM) ?
      32'(true_reg[rsel]) :
    in_blk(rif.rd_idx, rls_pkg::IDX_COMP, rls_pkg::NUM_TERM) ?
      32'(comp_reg[rsel]) :
    in_blk(rif.rd_idx, rls_pkg::IDX_SUM, rls_pkg::NUM_SUM) ? sum_reg[rsel] :
    (rif.rd_idx == rls_pkg::IDX_POL)  ? 32'(pol_reg)  :
    (rif.rd_idx == rls_pkg::IDX_MODE) ? 32'(mode_reg) :
    (rif.rd_idx == rls_pkg::IDX_OUT)  ? 32'(out_reg)  :
    (rif.rd_idx == rls_pkg::IDX_STAT) ? stat_word : 32'h0000_0000;

  // Bit 16 is the complement array output
  // gate input set
  assign vars    = {comp_out, q_eff, bio_in, in_pins};
  assign vars_nc = {1'b0, q_eff, bio_in, in_pins};

  // Position of the complement input in every mask
  assign comp_bit = 17'h0_0001 << rls_pkg::VAR_C;

  // First pass cuts complement links so the NOR has no loop
  for (genvar g = 0; g < rls_pkg::NUM_TERM; g++) begin : g_cut
    assign true_nc[g] = true_reg[g] & ~comp_bit;
    assign comp_nc[g] = comp_reg[g] & ~comp_bit;
  end

  rls_and_array u_and_nc (
    .vars      (vars_nc),
    .true_mask (true_nc),
    .comp_mask (comp_nc),
    .terms     (terms_nc)
  );

  // Sum 20 picks which logic gates feed it
  // complement NOR
  assign comp_out = ~|(terms_nc[rls_pkg::NUM_LOGIC-1:0] &
                       sum_reg[rls_pkg::SUM_C]);

  // Second pass sees the complement output
  // final product gates
  rls_and_array u_and (
    .vars      (vars),
    .true_mask (true_reg),
    .comp_mask (comp_reg),
    .terms     (terms)
  );

  for (genvar s = 0; s < rls_pkg::NUM_SUM; s++) begin : g_sum
    assign sums[s] = |(terms[rls_pkg::NUM_LOGIC-1:0] & sum_reg[s]);
  end

  // Direction gate high drives the line
  // line polarity and direction
  for (genvar b = 0; b < rls_pkg::NUM_BIO; b++) begin : g_bio
    assign bio_out[b] = sums[rls_pkg::SUM_B + b] ^ pol_reg[b];
    assign bio_oe[b]  = terms[rls_pkg::TERM_DIR + b];
  end

  // Flip-flop next state per mode
  for (genvar n = 0; n < rls_pkg::NUM_FF; n++) begin : g_ff
    rls_pkg::rls_ff_mode_e mode;   // Programmed mode
    logic                  j_in;   // J sum
    logic                  k_in;   // K after fold-back
    logic                  load;   // Load gate
    assign mode = rls_pkg::rls_ff_mode_e'(mode_reg[2*n +: 2]);
    assign j_in = sums[rls_pkg::SUM_J + n];
    assign k_in = (mode == rls_pkg::RLS_MODE_D) ? ~j_in :
                  (mode == rls_pkg::RLS_MODE_JKD &&
                   terms[rls_pkg::TERM_FOLD]) ? ~j_in :
                  (mode == rls_pkg::RLS_MODE_T) ? j_in :
                  sums[rls_pkg::SUM_K + n];
    // Flops share presets and resets in pairs
    // preset and reset sums
    assign pre[n] = sums[rls_pkg::SUM_PR + 2*(n/2)];
    assign clr[n] = sums[rls_pkg::SUM_PR + 2*(n/2) + 1];
    assign q_eff[n] = pre[n] | (~clr[n] & q_reg[n]);
    // Load beats J-K so a pin can preload
    // load from pin
    assign load = terms[rls_pkg::TERM_LOAD + n];
    assign q_next[n] = pre[n] ? 1'b1 :
                       clr[n] ? 1'b0 :
                       load   ? ~reg_in[n] :
                       (j_in & ~q_reg[n]) | (~k_in & q_reg[n]);
  end

  // Bus reset or the reset sum clears state; preset acts at once
  // rising edge state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= 4'h0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign reg_out = ~q_eff;

  // Per-pin select, gated by the pin or forced on
  // programmable output enable
  assign reg_oe = out_reg[3:0] & {rls_pkg::NUM_FF{out_reg[rls_pkg::OUT_ALWAYS] | ~oe_n}};
endmodule

/* sim/rls_sequencer_chk.sv */
// Bus and pin assertions for the sequencer top.
// Assumes a bind onto rls_sequencer and one clock domain.
module rls_sequencer_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // Read channels
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Registered pins
  input wire logic [3:0]  reg_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cleared state shows as high pins
  reset_pins_a: assert property ($rose(aresetn) |-> reg_out == 4'hF && !bvalid)
    else $error("pins or response not at reset level");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped or changed");
  read_ready_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer not withdrawn");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped or changed");
  write_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  read_error_a: assert property (rvalid && rresp == rls_pkg::RESP_SLVERR |-> rdata == 32'h0000_0000)
    else $error("refused read returns data");
endmodule

/* sim/rls_board.sv */
// Board logic around the pins: drives what the device leaves free.
// Assumes the bench supplies the board's own drive values.
module rls_board (
  // Device side
  input  wire logic [7:0] bio_out,
  input  wire logic [7:0] bio_oe,
  input  wire logic [3:0] reg_out,
  input  wire logic [3:0] reg_oe,
  // Board drive values
  input  wire logic [7:0] bio_drv,
  input  wire logic [3:0] reg_drv,
  // Resolved levels
  output logic      [7:0] bio_in,
  output logic      [3:0] reg_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // enabled lines carry the device level
  assign bio_in = (bio_out & bio_oe) | (bio_drv & ~bio_oe);
  // floated pins carry the board level
  assign reg_in = (reg_out & reg_oe) | (reg_drv & ~reg_oe);
endmodule

/* sim/tb_rls_sequencer.sv */
// Self-checking bench: bus tasks, board model and a flop model.
// Assumes the checker and board files are compiled first.
bind rls_sequencer rls_sequencer_chk chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp,
  .reg_out);
module tb_rls_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  // Pins and board drive
  logic [3:0]  in_pins = 4'h0, reg_in, reg_out, reg_oe, reg_drv = 4'h0;
  logic [7:0]  bio_in, bio_out, bio_oe, bio_drv = 8'h00;
  logic        oe_n = 1'b0;
  // Model and bookkeeping
  logic [31:0] seed = 32'h0000_51A1;
  int          fails = 0, checks = 0, cyc = 0, q, j, k;
  always #2.5 aclk = ~aclk;
  rls_sequencer dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .in_pins, .bio_in, .bio_out, .bio_oe, .reg_in, .reg_out,
    .reg_oe, .oe_n);
  rls_board brd_u (.bio_out, .bio_oe, .reg_out, .reg_oe, .bio_drv, .reg_drv, .bio_in,
    .reg_in);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bus write, both halves offered together
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] er = rls_pkg::RESP_OKAY);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  // Bus read, data compared under a mask
  task automatic rdr(input logic [7:0] idx, input logic [31:0] ed, input logic [31:0] m,
                     input logic [1:0] er = rls_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk("rresp", rresp, er);
    chk("rdata", rdata & m, ed);
  endtask
  // One product gate's true and complement links
  task automatic gate(input logic [7:0] g, input logic [16:0] t, input logic [16:0] c);
    wr(rls_pkg::IDX_TRUE + g, {15'h0000, t});
    wr(rls_pkg::IDX_COMP + g, {15'h0000, c});
  endtask
  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Unprogrammed values, refused places
    rdr(rls_pkg::IDX_POL, 0, '1);
    rdr(rls_pkg::IDX_MODE, 0, '1);
    rdr(rls_pkg::IDX_OUT, 32'h0000_001F, '1);
    rdr(rls_pkg::IDX_TRUE + 8'd44, 32'h0001_FFFF, '1);
    rdr(8'hC4, 0, '1, rls_pkg::RESP_SLVERR);
    wr(rls_pkg::IDX_STAT, 0, rls_pkg::RESP_SLVERR);
    // Line 0 is input 0, line 1 is the complement array of input 1
    gate(0, 17'h0_0001, 0);
    gate(5, 17'h0_0002, 0);
    gate(6, 17'h1_0000, 0);
    gate(32, 0, 0);
    gate(33, 0, 0);
    wr(rls_pkg::IDX_SUM, 32'h0000_0001);
    wr(rls_pkg::IDX_SUM + 8'd1, 32'h0000_0040);
    wr(rls_pkg::IDX_SUM + 8'd20, 32'h0000_0020);
    for (int p = 0; p < 2; p++) begin
      wr(rls_pkg::IDX_POL, 32'(p * 3));
      repeat (4) begin
        v = xs();
        @(posedge aclk);
        in_pins <= v[3:0];
        bio_drv <= v[15:8];
        #1;
        chk("bio_out0", bio_out[0], v[0] ^ p[0]);
        chk("bio_out1", bio_out[1], !v[1] ^ p[0]);
        chk("bio_oe", bio_oe, 8'h03);
      end
    end
    // Flop 0: J from gate 1, K from gate 2, fold from gate 44
    gate(1, 17'h0_0002, 0);
    gate(2, 17'h0_0004, 0);
    gate(44, 17'h0_0008, 0);
    wr(rls_pkg::IDX_SUM + 8'd8, 32'h0000_0002);
    wr(rls_pkg::IDX_SUM + 8'd12, 32'h0000_0004);
    for (int m = 0; m < 4; m++) begin
      @(posedge aclk);
      in_pins <= 4'h4;
      wr(rls_pkg::IDX_MODE, 32'(m));
      q = 0;
      j = 0;
      repeat (12) begin
        v = xs();
        @(posedge aclk);
        in_pins <= v[3:0];
        @(posedge aclk);
        #1;
        // Edge one repeats the last inputs, edge two takes the new ones
        repeat (2) begin
          q = (j && !k) ? 1 : (!j && k) ? 0 : (j && k) ? !q : q;
          j = v[1];
          k = (m == 1 || (m == 3 && !v[3])) ? v[2] : (m == 2) ? j : !j;
        end
        chk("reg_out", reg_out[0], !q);
      end
    end
    @(posedge aclk);
    in_pins <= 4'h9;
    rdr(rls_pkg::IDX_STAT, 32'h0009_0000, 32'h000F_0000);
    // Output enable only from the pin
    wr(rls_pkg::IDX_OUT, 32'h0000_000F);
    for (int e = 0; e < 2; e++) begin
      @(posedge aclk);
      oe_n <= e[0];
      #1;
      chk("reg_oe", reg_oe, e ? 4'h0 : 4'hF);
    end
    // Load gate copies the floated pin level
    gate(40, 0, 0);
    repeat (4) begin
      v = xs();
      @(posedge aclk);
      reg_drv <= v[3:0];
      @(posedge aclk);
      #1;
      chk("reg_load", reg_out[0], v[0]);
    end
    // Preset from input 3 wins over reset, both without a clock
    gate(3, 17'h0_0008, 0);
    gate(4, 0, 0);
    wr(rls_pkg::IDX_SUM + 8'd16, 32'h0000_0008);
    wr(rls_pkg::IDX_SUM + 8'd17, 32'h0000_0010);
    chk("preset", reg_out[1:0], 2'h0);
    @(posedge aclk);
    in_pins <= 4'h0;
    #1;
    chk("reset", reg_out[1:0], 2'h3);
    end_of_test();
  end
endmodule
